// file: design/mcm_params.svh
// offsets, field positions, reset values and counts of the clock monitor
`ifndef MCM_PARAMS_SVH
`define MCM_PARAMS_SVH
// ****************************************************************
// register byte offsets
// ****************************************************************
`define MCM_OFS_SYSCLK_EN    8'h00
`define MCM_OFS_SYSCLK_DIS   8'h04
`define MCM_OFS_SYSCLK_STAT  8'h08
`define MCM_OFS_MAIN_OSC     8'h20
`define MCM_OFS_FREQ_METER   8'h24
`define MCM_OFS_PLL_A        8'h28
`define MCM_OFS_MASTER       8'h30
`define MCM_OFS_PROG0        8'h40
`define MCM_OFS_PROG1        8'h44
`define MCM_OFS_PROG2        8'h48
`define MCM_OFS_IRQ_EN       8'h60
`define MCM_OFS_IRQ_DIS      8'h64
`define MCM_OFS_STATUS       8'h68
`define MCM_OFS_IRQ_MASK     8'h6C
`define MCM_OFS_FAULT_CLR    8'h78
// ****************************************************************
// field positions
// ****************************************************************
`define MCM_MOR_FASTRC       0
`define MCM_MOR_XTAL         1
`define MCM_MOR_START_LSB    8
`define MCM_MOR_MAINSEL      24
`define MCM_MOR_FAIL_DETECT_ENABLE        25
`define MCM_PLL_DIV_LSB      0
`define MCM_PLL_CNT_LSB      8
`define MCM_PLL_MUL_LSB      16
`define MCM_CSS_LSB          0
`define MCM_CLOCK_SCALE_RATIO_LSB         4
`define MCM_FM_RDY           16
`define MCM_SR_OSC_RDY       0
`define MCM_SR_LOCK          1
`define MCM_SR_MCK_RDY       3
`define MCM_SR_PCK_LSB       8
`define MCM_SR_CFD_EV        18
`define MCM_SR_CFD_ST        19
`define MCM_SR_FOS           20
`define MCM_IRQ_BITS         32'h0004_070B
// ****************************************************************
// reset values and counts
// ****************************************************************
`define MCM_RST_MOR          32'h0000_0001
`define MCM_RST_PLL          32'h0000_3F00
`define MCM_RST_MCKR         32'h0000_0001
`define MCM_FAIL_MIN_EDGES   4'h8
`define MCM_START_SHIFT      3
`define MCM_FM_WINDOW        5'h10
`define MCM_MCK_SWITCH       3'h4
`endif

// file: design/mcm_pkg.sv
// types shared by the clock monitor and its users
package mcm_pkg;
	// avalon request group
	typedef struct packed {
		logic        read;
		logic        write;
		logic [7:0]  address;
		logic [31:0] writedata;
	} mcm_avs_req_t;
	// clock steering towards the clock tree
	typedef struct packed {
		logic [1:0]       mck_src;
		logic [2:0]       mck_clock_scale_ratio;
		logic             main_from_xtal;
		logic             fast_rc_en;
		logic             xtal_en;
		logic [11:0]      pll_ratio;
		logic [2:0]       pck_en;
		logic [2:0][1:0]  pck_src;
		logic [2:0][2:0]  pck_clock_scale_ratio;
	} mcm_clk_ctrl_t;
endpackage : mcm_pkg

// file: design/mcm_clock_monitor.sv
// crystal failure monitor and clock sequencer with avalon register slave
//
// Operation
// [RULE1] detector off at reset, needs enable and crystal
// [RULE2] count crystal edges in slow high; under 8 fails
// [RULE3] failure sets sticky event flag; irq until status read
// [RULE4] live detector state bit in status
// [RULE5] crystal main plus pll master forces master to main
// [RULE6] failure moves main to fast rc, re-enables it
// [RULE7] detect and switch within two or three slow cycles
// [RULE8] fault output held until software clear; readable
// [RULE9] oscillator ready after eight times startup slow cycles
// [RULE10] meter counts main edges over sixteen slow cycles
// [RULE11] pll divider resets zero; software sets one
// [RULE12] multiplier zero is off, else ratio plus one
// [RULE13] lock after settle count; rewrite drops lock
// [RULE14] master prescaler 1,2,3,4,8..64; reset main undivided
// [RULE15] master source or prescaler change drops ready
// [RULE16] software changes source and prescaler separately
// [RULE17] pll rewrite runs master from slow until relock
// [RULE18] three prog outputs, set and clear enables, off
// [RULE19] prog source main/slow/pll/usb, power-two divide
// [RULE20] prog ready set once enabled and configured
// [RULE21] software disables prog output before reconfiguring
// [RULE22] ready and lock flags raise the interrupt
// [RULE23] external clocks synchronised before any status update
// [RULE24] source select in master register; divide three
//
// Added by the designer: the Avalon-MM slave port and the register offsets.
`timescale 1ns/1ps
`include "mcm_params.svh"
module mcm_clock_monitor (
	input  wire logic                  CLK,
	input  wire logic                  RSTN,
	input  wire mcm_pkg::mcm_avs_req_t AVS_REQ,
	output logic [31:0]                AVS_READDATA,
	output logic                       AVS_WAITREQUEST,
	input  wire logic                  SLOW_CLK,
	input  wire logic                  XTAL_CLK,
	input  wire logic                  FAST_RC_CLK,
	output logic                       FAULT_OUT,
	output logic                       IRQ,
	output mcm_pkg::mcm_clk_ctrl_t     CLK_CTRL
);
	import mcm_pkg::*;
	// ****************************************************************
	// synchronisers and edges
	// ****************************************************************
	logic [2:0] slk_ff;            // slow clock sync, [0] feeds [1] only
	logic [2:0] xtl_ff;            // crystal sync
	logic [2:0] frc_ff;            // fast rc sync
	logic       slow_rise;         // slow clock rising
	logic       slow_fall;         // slow clock falling
	logic       xtal_rise;         // crystal rising
	logic       frc_rise;          // fast rc rising

	// three stage shift per input; stage 0 is read by stage 1 only
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			slk_ff <= 3'h0;
			xtl_ff <= 3'h0;
			frc_ff <= 3'h0;
		end else begin
			slk_ff <= {slk_ff[1:0], SLOW_CLK};  // RULE23
			xtl_ff <= {xtl_ff[1:0], XTAL_CLK};  // RULE23
			frc_ff <= {frc_ff[1:0], FAST_RC_CLK};
		end
	end
	assign slow_rise = slk_ff[1] & ~slk_ff[2];
	assign slow_fall = ~slk_ff[1] & slk_ff[2];
	assign xtal_rise = xtl_ff[1] & ~xtl_ff[2];
	assign frc_rise  = frc_ff[1] & ~frc_ff[2];

	// ****************************************************************
	// avalon slave handshake
	// ****************************************************************
	logic        waitreq_ff;       // one wait state per access
	logic        req;              // read or write pending
	logic        acc;              // access completes this edge
	logic        acc_wr;           // write completes
	logic        acc_rd;           // read completes
	logic [7:0]  addr;             // byte address
	logic [31:0] wd;               // write data
	logic [31:0] rd_word;          // read mux
	logic [31:0] rdata_ff;         // registered read data

	assign req    = AVS_REQ.read | AVS_REQ.write;
	assign acc    = req & ~waitreq_ff;
	assign acc_wr = acc & AVS_REQ.write;
	assign acc_rd = acc & AVS_REQ.read;
	assign addr   = AVS_REQ.address;
	assign wd     = AVS_REQ.writedata;

	// waitrequest drops one cycle after the request, rises after taking
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			waitreq_ff <= 1'b1;
		end else begin
			waitreq_ff <= ~(req & waitreq_ff);
		end
	end

	// read data captured in the wait cycle, held until the next read
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			rdata_ff <= 32'h0000_0000;
		end else if (AVS_REQ.read && waitreq_ff) begin
			rdata_ff <= rd_word;
		end
	end

	// ****************************************************************
	// configuration registers
	// ****************************************************************
	logic        fastrc_en_ff;     // fast rc oscillator enable
	logic        xtal_en_ff;       // crystal_osc_enable
	logic [7:0]  start_ff;         // crystal_startup_time
	logic        mainsel_ff;       // main_source_is_crystal
	logic        cfd_en_ff;        // fail_detect_enable
	logic [7:0]  div_ff;           // pll input divider
	logic [5:0]  settle_ff;        // pll_settle_count
	logic [10:0] mul_ff;           // pll_feedback_factor
	logic [1:0]  css_ff;           // source_select of master clock
	logic [2:0]  clock_scale_ratio_ff;          // clock_scale_ratio, 7 means three
	logic [2:0]  pck_en_ff;        // prog output enables
	logic [2:0][1:0] pck_css_ff;   // prog output source
	logic [2:0][2:0] pck_clock_scale_ratio_ff;  // prog output power of two
	logic [31:0] imr_ff;           // interrupt mask
	logic        fail_pulse;       // failure declared this cycle
	logic        wr_mor;           // main_osc_reg written
	logic        wr_pll;           // pll_a_config_reg written
	logic        wr_mck_chg;       // master_clock_reg changed
	logic        force_main;       // failure pulls master off pll
	logic [2:0]  wr_pck;           // prog_output_config_reg written
	// reset words as constants, so their fields can be selected
	localparam logic [31:0] rst_mor  = `MCM_RST_MOR;   // main_osc_reg reset word
	localparam logic [31:0] rst_pll  = `MCM_RST_PLL;   // pll_a_config_reg reset word
	localparam logic [31:0] rst_mckr = `MCM_RST_MCKR;  // master_clock_reg reset word

	assign wr_mor     = acc_wr && addr == `MCM_OFS_MAIN_OSC;
	assign wr_pll     = acc_wr && addr == `MCM_OFS_PLL_A;
	assign wr_mck_chg = acc_wr && addr == `MCM_OFS_MASTER &&
		(wd[`MCM_CSS_LSB +: 2] != css_ff || wd[`MCM_CLOCK_SCALE_RATIO_LSB +: 3] != clock_scale_ratio_ff);  // RULE15
	assign force_main = fail_pulse && mainsel_ff && css_ff[1];  // RULE5
	assign wr_pck[0]  = acc_wr && addr == `MCM_OFS_PROG0;
	assign wr_pck[1]  = acc_wr && addr == `MCM_OFS_PROG1;
	assign wr_pck[2]  = acc_wr && addr == `MCM_OFS_PROG2;

	// main oscillator register; a failure overrides the same edge's write
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			fastrc_en_ff <= rst_mor[`MCM_MOR_FASTRC];
			xtal_en_ff   <= rst_mor[`MCM_MOR_XTAL];
			start_ff     <= rst_mor[`MCM_MOR_START_LSB +: 8];
			mainsel_ff   <= rst_mor[`MCM_MOR_MAINSEL];
			cfd_en_ff    <= rst_mor[`MCM_MOR_FAIL_DETECT_ENABLE];  // RULE1
		end else begin
			if (wr_mor) begin
				fastrc_en_ff <= wd[`MCM_MOR_FASTRC];
				xtal_en_ff   <= wd[`MCM_MOR_XTAL];
				start_ff     <= wd[`MCM_MOR_START_LSB +: 8];
				mainsel_ff   <= wd[`MCM_MOR_MAINSEL];
				cfd_en_ff    <= wd[`MCM_MOR_FAIL_DETECT_ENABLE];
			end
			if (fail_pulse) begin
				mainsel_ff   <= 1'b0;  // RULE6
				fastrc_en_ff <= 1'b1;  // RULE6
			end
		end
	end

	// pll register; divider and multiplier reset to zero, pll off
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			div_ff    <= rst_pll[`MCM_PLL_DIV_LSB +: 8];  // RULE11
			settle_ff <= rst_pll[`MCM_PLL_CNT_LSB +: 6];
			mul_ff    <= rst_pll[`MCM_PLL_MUL_LSB +: 11];
		end else if (wr_pll) begin
			div_ff    <= wd[`MCM_PLL_DIV_LSB +: 8];
			settle_ff <= wd[`MCM_PLL_CNT_LSB +: 6];
			mul_ff    <= wd[`MCM_PLL_MUL_LSB +: 11];  // RULE12
		end
	end

	// master clock register, main undivided after reset
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			css_ff  <= rst_mckr[`MCM_CSS_LSB +: 2];   // RULE14
			clock_scale_ratio_ff <= rst_mckr[`MCM_CLOCK_SCALE_RATIO_LSB +: 3];  // RULE14
		end else if (force_main) begin
			css_ff  <= 2'h1;  // RULE5
		end else if (acc_wr && addr == `MCM_OFS_MASTER) begin
			css_ff  <= wd[`MCM_CSS_LSB +: 2];   // RULE24
			clock_scale_ratio_ff <= wd[`MCM_CLOCK_SCALE_RATIO_LSB +: 3];  // RULE14
		end
	end

	// prog outputs: write-one enable and disable, config per output
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			pck_en_ff   <= 3'h0;                 // RULE18
			pck_css_ff  <= '0;                   // RULE19
			pck_clock_scale_ratio_ff <= '0;                   // RULE19
		end else begin
			if (acc_wr && addr == `MCM_OFS_SYSCLK_EN)
				pck_en_ff <= pck_en_ff | wd[2:0];   // RULE18
			if (acc_wr && addr == `MCM_OFS_SYSCLK_DIS)
				pck_en_ff <= pck_en_ff & ~wd[2:0];  // RULE18
			for (int i = 0; i < 3; i++) begin
				if (wr_pck[i]) begin
					pck_css_ff[i]  <= wd[`MCM_CSS_LSB +: 2];
					pck_clock_scale_ratio_ff[i] <= wd[`MCM_CLOCK_SCALE_RATIO_LSB +: 3];
				end
			end
		end
	end

	// interrupt mask: set and clear registers
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			imr_ff <= 32'h0000_0000;
		end else if (acc_wr && addr == `MCM_OFS_IRQ_EN) begin
			imr_ff <= imr_ff | (wd & `MCM_IRQ_BITS);
		end else if (acc_wr && addr == `MCM_OFS_IRQ_DIS) begin
			imr_ff <= imr_ff & ~wd;
		end
	end

	// ****************************************************************
	// crystal failure detector
	// ****************************************************************
	logic       det_on;            // detector running
	logic [3:0] xcnt_ff;           // crystal edges in slow high, saturating
	logic       cfd_st_ff;         // fail_detect_state
	logic       cfd_ev_ff;         // fail_event_flag
	logic       fos_ff;            // fault_out_state

	assign det_on     = cfd_en_ff & xtal_en_ff;  // RULE1
	assign fail_pulse = det_on && slow_fall && xcnt_ff < `MCM_FAIL_MIN_EDGES;  // RULE2

	// counter held clear while slow is low, counts while high
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			xcnt_ff <= 4'h0;
		end else if (!slk_ff[1]) begin
			xcnt_ff <= 4'h0;  // RULE2
		end else if (xtal_rise && xcnt_ff < `MCM_FAIL_MIN_EDGES) begin
			xcnt_ff <= xcnt_ff + 4'h1;  // RULE2
		end
	end

	// live state follows the last decision, off with the detector
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			cfd_st_ff <= 1'b0;
		end else if (!det_on) begin
			cfd_st_ff <= 1'b0;  // RULE1
		end else if (slow_fall) begin
			cfd_st_ff <= fail_pulse;  // RULE4
		end
	end

	// sticky event: set wins over the status read that clears it
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			cfd_ev_ff <= 1'b0;
		end else if (fail_pulse) begin
			cfd_ev_ff <= 1'b1;  // RULE3
		end else if (acc_rd && addr == `MCM_OFS_STATUS) begin
			cfd_ev_ff <= 1'b0;  // RULE3
		end
	end

	// fault output: set wins over the software clear
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			fos_ff <= 1'b0;
		end else if (fail_pulse) begin
			fos_ff <= 1'b1;  // RULE8
		end else if (acc_wr && addr == `MCM_OFS_FAULT_CLR && wd[0]) begin
			fos_ff <= 1'b0;  // RULE8
		end
	end

	// ****************************************************************
	// oscillator start-up, pll lock, frequency meter
	// ****************************************************************
	logic [10:0] osc_cnt_ff;       // start-up slow cycles left
	logic        osc_rdy_ff;       // crystal_osc_ready
	logic [5:0]  pll_cnt_ff;       // settle slow cycles left
	logic        lock_ff;          // pll lock
	logic        pll_on;           // pll running
	logic [4:0]  fm_win_ff;        // slow edges in window
	logic [15:0] fm_acc_ff;        // main edges counted
	logic [15:0] fm_cnt_ff;        // main_freq_count
	logic        fm_rdy_ff;        // freq_meter_ready

	assign pll_on = mul_ff != 11'h000 && div_ff != 8'h00;  // RULE12

	// start-up count loads on crystal enable, counts slow rises
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			osc_cnt_ff <= 11'h000;
			osc_rdy_ff <= 1'b0;
		end else if (wr_mor && wd[`MCM_MOR_XTAL] && !xtal_en_ff) begin
			// take the start-up value written with the enable itself
			osc_rdy_ff <= 1'b0;
			osc_cnt_ff <= {wd[`MCM_MOR_START_LSB +: 8], 3'h0};  // RULE9
		end else if (!xtal_en_ff) begin
			osc_rdy_ff <= 1'b0;
			osc_cnt_ff <= 11'h000;
		end else if (osc_cnt_ff == 11'h000) begin
			osc_rdy_ff <= 1'b1;  // RULE9
		end else if (slow_rise) begin
			osc_cnt_ff <= osc_cnt_ff - 11'h001;  // RULE9
		end
	end

	// lock drops on every pll write and returns after the settle count
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			pll_cnt_ff <= 6'h00;
			lock_ff    <= 1'b0;
		end else if (wr_pll) begin
			pll_cnt_ff <= wd[`MCM_PLL_CNT_LSB +: 6];  // RULE13
			lock_ff    <= 1'b0;                       // RULE13
		end else if (pll_cnt_ff != 6'h00) begin
			if (slow_rise)
				pll_cnt_ff <= pll_cnt_ff - 6'h01;
		end else begin
			lock_ff <= pll_on;  // RULE13
		end
	end

	// main edges over sixteen slow cycles, restarted by each window
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			fm_win_ff <= 5'h00;
			fm_acc_ff <= 16'h0000;
			fm_cnt_ff <= 16'h0000;
			fm_rdy_ff <= 1'b0;
		end else if (slow_rise && fm_win_ff == `MCM_FM_WINDOW - 5'h01) begin
			fm_cnt_ff <= fm_acc_ff;  // RULE10
			fm_rdy_ff <= 1'b1;       // RULE10
			fm_win_ff <= 5'h00;
			fm_acc_ff <= 16'h0000;
		end else begin
			if (slow_rise)
				fm_win_ff <= fm_win_ff + 5'h01;
			if (mainsel_ff ? xtal_rise : frc_rise)
				fm_acc_ff <= fm_acc_ff + 16'h0001;
		end
	end

	// ****************************************************************
	// master clock ready and prog output ready
	// ****************************************************************
	logic [2:0] mck_wait_ff;       // slow cycles until switched
	logic       mck_rdy_ff;        // master_clock_ready
	logic       pll_hold;          // master on unlocked pll
	logic [2:0] pck_rdy_ff;        // prog_output_ready

	assign pll_hold = css_ff == 2'h2 && !lock_ff;  // RULE17

	// ready drops on any change and rises after the switch time
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			mck_wait_ff <= 3'h0;
			mck_rdy_ff  <= 1'b1;
		end else if (wr_mck_chg || force_main || (wr_pll && css_ff == 2'h2)) begin
			mck_wait_ff <= `MCM_MCK_SWITCH;  // RULE15
			mck_rdy_ff  <= 1'b0;             // RULE15
		end else if (mck_wait_ff != 3'h0) begin
			if (slow_rise)
				mck_wait_ff <= mck_wait_ff - 3'h1;
		end else begin
			mck_rdy_ff <= !pll_hold;  // RULE17
		end
	end

	// prog ready follows the enable at the next slow rise
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			pck_rdy_ff <= 3'h0;
		end else begin
			for (int i = 0; i < 3; i++) begin
				if (!pck_en_ff[i] || wr_pck[i])
					pck_rdy_ff[i] <= 1'b0;
				else if (slow_rise)
					pck_rdy_ff[i] <= 1'b1;  // RULE20
			end
		end
	end

	// ****************************************************************
	// status, read mux and outputs
	// ****************************************************************
	logic [31:0] sr_word;          // power_status_reg
	logic        irq_ff;           // interrupt line
	logic        fault_ff;         // fault to pwm
	mcm_clk_ctrl_t ctrl_ff;        // clock steering

	// status word assembly
	always_comb begin
		sr_word = 32'h0000_0000;
		sr_word[`MCM_SR_OSC_RDY] = osc_rdy_ff;
		sr_word[`MCM_SR_LOCK]    = lock_ff;
		sr_word[`MCM_SR_MCK_RDY] = mck_rdy_ff;
		sr_word[`MCM_SR_PCK_LSB +: 3] = pck_rdy_ff;
		sr_word[`MCM_SR_CFD_EV]  = cfd_ev_ff;
		sr_word[`MCM_SR_CFD_ST]  = cfd_st_ff;  // RULE4
		sr_word[`MCM_SR_FOS]     = fos_ff;     // RULE8
	end

	// read mux; unmapped and write-only offsets read zero
	always_comb begin
		rd_word = 32'h0000_0000;
		unique case (addr)
			`MCM_OFS_SYSCLK_STAT: rd_word[2:0] = pck_en_ff;
			`MCM_OFS_MAIN_OSC: begin
				rd_word[`MCM_MOR_FASTRC] = fastrc_en_ff;
				rd_word[`MCM_MOR_XTAL]   = xtal_en_ff;
				rd_word[`MCM_MOR_START_LSB +: 8] = start_ff;
				rd_word[`MCM_MOR_MAINSEL] = mainsel_ff;
				rd_word[`MCM_MOR_FAIL_DETECT_ENABLE]  = cfd_en_ff;
			end
			`MCM_OFS_FREQ_METER: rd_word = {15'h0000, fm_rdy_ff, fm_cnt_ff};
			`MCM_OFS_PLL_A: rd_word = {5'h00, mul_ff, 2'h0, settle_ff, div_ff};
			`MCM_OFS_MASTER: rd_word = {25'h0000000, clock_scale_ratio_ff, 2'h0, css_ff};
			`MCM_OFS_PROG0: rd_word = {25'h0000000, pck_clock_scale_ratio_ff[0], 2'h0, pck_css_ff[0]};
			`MCM_OFS_PROG1: rd_word = {25'h0000000, pck_clock_scale_ratio_ff[1], 2'h0, pck_css_ff[1]};
			`MCM_OFS_PROG2: rd_word = {25'h0000000, pck_clock_scale_ratio_ff[2], 2'h0, pck_css_ff[2]};
			`MCM_OFS_STATUS: rd_word = sr_word;
			`MCM_OFS_IRQ_MASK: rd_word = imr_ff;
			default: rd_word = 32'h0000_0000;
		endcase
	end

	// registered outputs
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			irq_ff   <= 1'b0;
			fault_ff <= 1'b0;
			ctrl_ff  <= '0;
			// steering shows the register reset state: main, fast rc on
			ctrl_ff.mck_src    <= rst_mckr[`MCM_CSS_LSB +: 2];  // RULE14
			ctrl_ff.fast_rc_en <= rst_mor[`MCM_MOR_FASTRC];
		end else begin
			irq_ff   <= |(sr_word & imr_ff);  // RULE22
			fault_ff <= fos_ff;               // RULE8
			ctrl_ff.mck_src        <= pll_hold ? 2'h0 : css_ff;  // RULE17
			ctrl_ff.mck_clock_scale_ratio       <= clock_scale_ratio_ff;
			ctrl_ff.main_from_xtal <= mainsel_ff;  // RULE7
			ctrl_ff.fast_rc_en     <= fastrc_en_ff;
			ctrl_ff.xtal_en        <= xtal_en_ff;
			ctrl_ff.pll_ratio      <= pll_on ? {1'b0, mul_ff} + 12'h001 : 12'h000;  // RULE12
			ctrl_ff.pck_en         <= pck_en_ff;
			ctrl_ff.pck_src        <= pck_css_ff;
			ctrl_ff.pck_clock_scale_ratio       <= pck_clock_scale_ratio_ff;
		end
	end
	assign AVS_READDATA    = rdata_ff;
	assign AVS_WAITREQUEST = waitreq_ff;
	assign FAULT_OUT       = fault_ff;
	assign IRQ             = irq_ff;
	assign CLK_CTRL        = ctrl_ff;

	// ****************************************************************
	// assertions
	// ****************************************************************
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RSTN);
	sequence s_fail;
		fail_pulse;
	endsequence
	sequence s_ev_then_irq;
		##1 cfd_ev_ff ##1 (IRQ || !imr_ff[`MCM_SR_CFD_EV]);
	endsequence
	det_gated_a:  assert property (!(cfd_en_ff && xtal_en_ff) && !fos_ff |=> !fos_ff && !cfd_st_ff)  // RULE1
		else $error("failure declared with detector off");
	thresh_a:     assert property (slow_fall && det_on |=> cfd_st_ff == ($past(xcnt_ff) < 4'h8))  // RULE2
		else $error("failure decision wrong for edge count");
	event_irq_a:  assert property (s_fail |-> s_ev_then_irq)  // RULE3
		else $error("event or interrupt missing after failure");
	auto_main_a:  assert property (fail_pulse && mainsel_ff && css_ff[1] |=> css_ff == 2'h1)  // RULE5
		else $error("master not moved to main");
	fastrc_a:     assert property (s_fail |=> fastrc_en_ff && !mainsel_ff ##1 !CLK_CTRL.main_from_xtal)  // RULE6
		else $error("main not moved to fast rc");
	fault_hold_a: assert property (fos_ff && !(acc_wr && addr == `MCM_OFS_FAULT_CLR) |=> fos_ff)  // RULE8
		else $error("fault output dropped without clear");
	lock_drop_a:  assert property (wr_pll && wd[`MCM_PLL_CNT_LSB +: 6] != 6'h00 |=> !lock_ff ##1 !lock_ff)  // RULE13
		else $error("lock not dropped after pll write");
	mck_drop_a:   assert property (wr_mck_chg |=> !mck_rdy_ff [*2])  // RULE15
		else $error("master ready not dropped");
	pll_slow_a:   assert property (pll_hold |=> !mck_rdy_ff && CLK_CTRL.mck_src == 2'h0)  // RULE17
		else $error("master not on slow while unlocked");
endmodule : mcm_clock_monitor

// file: bench/mcm_clk_partner.sv
// clock sources: slow rc, a crystal that can stop, free fast rc
`timescale 1ns/1ps
module mcm_clk_partner (
	input  wire logic XTAL_STOP,
	output logic      SLOW_CLK,
	output logic      XTAL_CLK,
	output logic      FAST_RC_CLK
);
	// slow rc, 640 ns period: about 16 crystal rises per high phase
	initial SLOW_CLK = 1'b0;
	always #320 SLOW_CLK = ~SLOW_CLK;
	// crystal at 50 MHz; a dead crystal sits low
	initial XTAL_CLK = 1'b0;
	always #10 XTAL_CLK = XTAL_STOP ? 1'b0 : ~XTAL_CLK;
	// fast rc runs free
	initial FAST_RC_CLK = 1'b0;
	always #12 FAST_RC_CLK = ~FAST_RC_CLK;
endmodule : mcm_clk_partner

// file: bench/tb_main_clock_monitor_and_sequencer.sv
// self-checking bench of the clock monitor
`timescale 1ns/1ps
`include "mcm_params.svh"
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin n_errors++; \
	$display("unexpected %s exp %h got %h", n, e, s); end end
module tb_main_clock_monitor_and_sequencer;
	import mcm_pkg::*;
	logic          CLK, RSTN, xtal_stop;   // clock, reset, crystal kill
	mcm_avs_req_t  req;                    // avalon request
	logic [31:0]   rd_bus, rdata;          // read data live and taken
	logic          wreq, fault, irq;       // design outputs
	logic          slow, xtal, frc;        // partner clocks
	mcm_clk_ctrl_t ctrl;                   // clock steering
	int            n_errors, comparisons, seed, v;
	logic [31:0]   model [int];            // expected register contents
	mcm_clock_monitor i_dut (.CLK(CLK), .RSTN(RSTN), .AVS_REQ(req), .AVS_READDATA(rd_bus),
		.AVS_WAITREQUEST(wreq), .SLOW_CLK(slow), .XTAL_CLK(xtal), .FAST_RC_CLK(frc),
		.FAULT_OUT(fault), .IRQ(irq), .CLK_CTRL(ctrl));
	mcm_clk_partner i_src (.XTAL_STOP(xtal_stop), .SLOW_CLK(slow), .XTAL_CLK(xtal),
		.FAST_RC_CLK(frc));
	always #2 CLK = ~CLK;
	// one access, held until waitrequest is sampled low
	task automatic bus(input logic rd, input logic [7:0] a, input logic [31:0] d);
		@(posedge CLK);
		req <= '{read: rd, write: ~rd, address: a, writedata: d};
		do @(posedge CLK); while (wreq !== 1'b0);
		rdata = rd_bus;
		req <= '0;
	endtask : bus
	// write and record in the model
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b0, a, d);
		model[a] = d;
	endtask : wr
	// read and compare the masked bits
	task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		bus(1'b1, a, 32'h0);
		`CHK("read", e & m, rdata & m)
	endtask : rd
	// verdict and end of run
	task automatic complete_run();
		if (n_errors == 0 && comparisons > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : complete_run
	// watchdog against a hang
	initial begin
		#100000;
		n_errors++;
		complete_run();
	end
	// ****************************************************************
	// main sequence
	// ****************************************************************
	initial begin
		CLK = 0; RSTN = 0; req = '0; xtal_stop = 0; seed = 32'hA976;
		model[`MCM_OFS_MAIN_OSC] = `MCM_RST_MOR; model[`MCM_OFS_PLL_A] = `MCM_RST_PLL;
		model[`MCM_OFS_MASTER] = `MCM_RST_MCKR; model[`MCM_OFS_PROG0] = 32'h0;
		model[`MCM_OFS_STATUS] = 32'h8; model[8'h7C] = 32'h0; model[`MCM_OFS_SYSCLK_STAT] = 0;
		repeat (4) @(posedge CLK);
		RSTN <= 1'b1;
		@(negedge CLK);
		`CHK("mck_src", 2'h1, ctrl.mck_src)
		`CHK("mck_clock_scale_ratio", 3'h0, ctrl.mck_clock_scale_ratio)
		foreach (model[a]) rd(a[7:0], 32'hFFFF_FFFF, model[a]);
		// random legal configurations of the three outputs
		for (int i = 0; i < 3; i++) begin
			v = $random(seed);
			wr(8'h40 + 8'(4 * i), {25'h0, (v[6:4] == 3'h7) ? 3'h6 : v[6:4], 2'h0, v[1:0]});
			rd(8'h40 + 8'(4 * i), 32'hFFFF_FFFF, model[8'h40 + 4 * i]);
		end
		wr(`MCM_OFS_SYSCLK_EN, 32'h7);
		wr(`MCM_OFS_SYSCLK_DIS, 32'h2);
		repeat (400) @(posedge CLK);
		rd(`MCM_OFS_SYSCLK_STAT, 32'h7, 32'h5);
		rd(`MCM_OFS_STATUS, 32'h700, 32'h500);
		// crystal on with start-up 1 (eight slow cycles), detector on, master onto the unlocked pll
		wr(`MCM_OFS_IRQ_EN, 32'h0004_0000);
		wr(`MCM_OFS_MAIN_OSC, 32'h0300_0103);
		wr(`MCM_OFS_MASTER, 32'h0000_0002);
		repeat (4) @(posedge CLK);
		`CHK("mck_src", 2'h0, ctrl.mck_src)
		rd(`MCM_OFS_STATUS, 32'h0000_0009, 32'h0);
		// pll divider one, factor nine, settle two slow cycles
		wr(`MCM_OFS_PLL_A, 32'h0009_0201);
		repeat (1600) @(posedge CLK);
		rd(`MCM_OFS_STATUS, 32'h001C_000B, 32'hB);
		`CHK("mck_src", 2'h2, ctrl.mck_src)
		`CHK("pll_ratio", 12'h00A, ctrl.pll_ratio)
		// kill the crystal at the start of a slow low phase
		@(negedge slow);
		@(posedge CLK);
		xtal_stop <= 1'b1;
		repeat (320) @(posedge CLK);
		`CHK("fault", 1'b1, fault)
		`CHK("irq", 1'b1, irq)
		`CHK("xtal_main", 1'b0, ctrl.main_from_xtal)
		`CHK("fast_rc", 1'b1, ctrl.fast_rc_en)
		`CHK("mck_src", 2'h1, ctrl.mck_src)
		rd(`MCM_OFS_STATUS, 32'h001C_0000, 32'h001C_0000);
		wr(`MCM_OFS_MAIN_OSC, 32'h1);
		bus(1'b1, `MCM_OFS_STATUS, 32'h0);
		rd(`MCM_OFS_STATUS, 32'h001C_0000, 32'h0010_0000);
		repeat (3) @(posedge CLK);
		`CHK("irq", 1'b0, irq)
		wr(`MCM_OFS_FAULT_CLR, 32'h1);
		repeat (3) @(posedge CLK);
		`CHK("fault", 1'b0, fault)
		// meter window of sixteen slow cycles has long closed by now
		repeat (600) @(posedge CLK);
		rd(`MCM_OFS_FREQ_METER, 32'h0001_0000, 32'h0001_0000);
		complete_run();
	end
endmodule : tb_main_clock_monitor_and_sequencer
